//--- logic/eci_pkg.sv
`default_nettype none
package eci_pkg;
  localparam int unsigned NCH     = 2;
  localparam int unsigned REQ_MAX = 5;
  localparam int unsigned IRQ_W   = 4;

  localparam logic [7:0] A_REQ_BYTE = 8'h00;
  localparam logic [7:0] A_REQ_TEXT = 8'h04;
  localparam logic [7:0] A_EXEC     = 8'h08;
  localparam logic [7:0] A_INFO     = 8'h0c;
  localparam logic [7:0] A_DIAG     = 8'h10;
  localparam logic [7:0] A_ENG      = 8'h14;
  localparam logic [7:0] A_IRQ_ST   = 8'h18;
  localparam logic [7:0] A_IRQ_EN   = 8'h1c;
  localparam logic [7:0] A_IRQ_CLR  = 8'h20;
  localparam logic [2:0] A_CH_REGION = 3'h2;
  localparam logic [1:0] R_STAT  = 2'h0;
  localparam logic [1:0] R_RESP0 = 2'h1;
  localparam logic [1:0] R_RESP1 = 2'h2;
  localparam logic [1:0] R_OFS   = 2'h3;

  localparam logic [15:0] CMD_DIAG_CLR  = 16'h1000;
  localparam logic [15:0] CMD_DIAG_TEST = 16'h1001;
  localparam logic [15:0] CMD_ENC_RST   = 16'h8001;
  localparam logic [15:0] CMD_OFS_CALC  = 16'h8006;
  localparam logic [15:0] CMD_SUPP      = 16'h8008;

  localparam logic [7:0] STAT_IDLE = 8'h00;
  localparam logic [7:0] STAT_OK   = 8'h01;
  localparam logic [7:0] STAT_ERR  = 8'h02;
  localparam logic [7:0] CHR_SPACE = 8'h20;

  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_ERR  = 1;
  localparam int unsigned IRQ_NP   = 2;
  localparam int unsigned IRQ_RM   = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EMIT = 3'b010,
    S_ENC  = 3'b100
  } eci_state_t;

  typedef enum logic [1:0] {
    ENC_NONE  = 2'h0,
    ENC_RESET = 2'h1,
    ENC_POS2  = 2'h2
  } eci_mode_t;

  typedef struct packed {
    logic      req;
    eci_mode_t mode;
    logic      clr_words;
    logic      ch;
  } eci_enc_req_t;

  typedef struct packed {
    logic        done;
    logic [31:0] first_position_value;
    logic [31:0] second_position_value;
  } eci_enc_rsp_t;

  typedef struct packed {
    logic        vld;
    logic [31:0] info;
    logic [31:0] diag;
  } eci_np_t;
endpackage
`default_nettype wire

//--- logic/eci_cmd_interp.sv
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module eci_cmd_interp
  import eci_pkg::*;
#(
  parameter int unsigned N_DIAG = 8
)(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [31:0]           rdata,
  input  wire logic             preop,
  input  wire eci_np_t          np,
  output logic                  np_fetch,
  output eci_enc_req_t          enc_req,
  input  wire eci_enc_rsp_t     enc_rsp,
  input  wire logic [NCH-1:0]   reference_mark_flag,
  input  wire logic [NCH-1:0]   raw_tx_invalid,
  output logic [NCH-1:0]        transmit_data_invalid_flag,
  output logic                  diag_vld,
  output logic [7:0]            diag_id,
  output logic                  diag_ch,
  output logic                  irq
);

  typedef struct packed {
    eci_state_t                state;
    logic [REQ_MAX-1:0][7:0]   req;
    logic [2:0]                req_len;
    logic [3:0]                txt_acc;
    logic [1:0]                txt_cnt;
    logic                      txt_bad;
    logic                      ch;
    logic [15:0]               code;
    logic [NCH-1:0][7:0]       stat;
    logic [NCH-1:0][47:0]      resp;
    logic [NCH-1:0][31:0]      ofs;
    logic [NCH-1:0][7:0]       logcnt;
    logic [NCH-1:0]            supp;
    logic [7:0]                emit_idx;
    logic                      preop_q;
    logic                      np_done;
    logic [31:0]               info;
    logic [31:0]               diag;
    logic [IRQ_W-1:0]          irq_st;
    logic [IRQ_W-1:0]          irq_en;
    logic                      irq;
    logic [31:0]               rdata;
    eci_enc_req_t              enc;
    logic                      np_fetch;
    logic                      diag_vld;
    logic [7:0]                diag_id;
    logic [NCH-1:0]            tx_inv;
  } eci_st_t;

  eci_st_t          st_q;
  eci_st_t          nxt_st;
  logic             go;
  logic             cmd_ok;
  logic             ch_in;
  logic [15:0]      code_in;
  logic [4:0]       nib;
  logic             push_en;
  logic [7:0]       push_byte;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [31:0]      ofs_new;

  // returns {valid, nibble} for an ascii hex digit
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      hex_nib = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      hex_nib = {1'b1, c[3:0] + 4'h9};
    else
      hex_nib = 5'h00;
  endfunction

  function automatic logic in_ch(input logic [7:0] a);
    in_ch = (a[7:5] == A_CH_REGION);
  endfunction

  assign ch_in   = wdata[0];
  assign code_in = {st_q.req[1], st_q.req[0]};
  assign go      = wr && addr == A_EXEC && st_q.state == S_IDLE;
  assign cmd_ok  = go && !st_q.txt_bad && st_q.req_len >= 3'h2;
  assign nib     = hex_nib(wdata[7:0]);
  assign ofs_new = enc_rsp.first_position_value - enc_rsp.second_position_value;

  always_comb
  begin
    nxt_st          = st_q;
    ev              = '0;
    clr             = '0;
    push_en         = 1'b0;
    push_byte       = '0;
    nxt_st.rdata    = '0;
    nxt_st.enc.req  = 1'b0;
    nxt_st.np_fetch = 1'b0;
    nxt_st.diag_vld = 1'b0;
    nxt_st.preop_q  = preop;

    if (preop && !st_q.preop_q)
    begin
      nxt_st.np_fetch = 1'b1;
      nxt_st.np_done  = 1'b0;
    end
    if (st_q.preop_q && np.vld && !st_q.np_done)
    begin
      nxt_st.info    = np.info;
      nxt_st.diag    = np.diag;
      nxt_st.np_done = 1'b1;
      ev[IRQ_NP]     = 1'b1;
    end

    for (int c = 0; c < NCH; c++)
    begin
      if (st_q.supp[c] && reference_mark_flag[c])
      begin
        nxt_st.supp[c] = 1'b0;
        ev[IRQ_RM]     = 1'b1;
      end
      nxt_st.tx_inv[c] = raw_tx_invalid[c] && !st_q.supp[c];
    end

    if (wr)
    begin
      case (addr)
        A_REQ_BYTE:
        begin
          push_en   = st_q.state == S_IDLE;
          push_byte = wdata[7:0];
        end
        A_REQ_TEXT:
          if (st_q.state == S_IDLE)
          begin
            if (wdata[7:0] == CHR_SPACE)
            begin
              push_en           = st_q.txt_cnt == 2'h1;
              push_byte         = {4'h0, st_q.txt_acc};
              nxt_st.txt_cnt    = 2'h0;
            end
            else if (!nib[4] || st_q.txt_cnt == 2'h2)
              nxt_st.txt_bad    = 1'b1;
            else if (st_q.txt_cnt == 2'h0)
            begin
              nxt_st.txt_acc    = nib[3:0];
              nxt_st.txt_cnt    = 2'h1;
            end
            else
            begin
              push_en           = 1'b1;
              push_byte         = {st_q.txt_acc, nib[3:0]};
              nxt_st.txt_cnt    = 2'h2;
            end
          end
        A_IRQ_EN:
          nxt_st.irq_en = wdata[IRQ_W-1:0];
        A_IRQ_CLR:
          clr = wdata[IRQ_W-1:0];
        default:
          if (in_ch(addr) && addr[3:2] == R_OFS)
            nxt_st.ofs[addr[4]] = wdata;
      endcase
    end

    // bytes beyond the header length are dropped; no command here needs more
    if (push_en && st_q.req_len < 3'(REQ_MAX))
    begin
      nxt_st.req[st_q.req_len] = push_byte;
      nxt_st.req_len           = st_q.req_len + 3'h1;
    end

    unique case (st_q.state)
      S_IDLE:
        if (go)
        begin
          nxt_st.code    = code_in;
          nxt_st.ch      = ch_in;
          nxt_st.req_len = '0;
          nxt_st.txt_cnt = '0;
          nxt_st.txt_bad = 1'b0;
          nxt_st.resp[ch_in] = {32'h0, code_in};
          if (!cmd_ok)
          begin
            nxt_st.stat[ch_in] = STAT_ERR;
            ev[IRQ_ERR]        = 1'b1;
          end
          else
          begin
            case (code_in)
              CMD_DIAG_CLR:
              begin
                nxt_st.logcnt[ch_in] = '0;
                nxt_st.stat[ch_in]   = STAT_IDLE;
                ev[IRQ_DONE]         = 1'b1;
              end
              CMD_DIAG_TEST:
              begin
                nxt_st.stat[ch_in] = STAT_IDLE;
                nxt_st.emit_idx    = '0;
                nxt_st.state       = S_EMIT;
              end
              CMD_ENC_RST, CMD_OFS_CALC:
              begin
                nxt_st.stat[ch_in]   = STAT_IDLE;
                nxt_st.enc.req       = 1'b1;
                nxt_st.enc.ch        = ch_in;
                nxt_st.enc.mode      = code_in == CMD_ENC_RST ? ENC_RESET : ENC_POS2;
                nxt_st.enc.clr_words = code_in == CMD_ENC_RST;
                nxt_st.state         = S_ENC;
              end
              CMD_SUPP:
              begin
                nxt_st.supp[ch_in] = 1'b1;
                nxt_st.stat[ch_in] = STAT_OK;
                ev[IRQ_DONE]       = 1'b1;
              end
              default:
              begin
                nxt_st.stat[ch_in] = STAT_ERR;
                ev[IRQ_ERR]        = 1'b1;
              end
            endcase
          end
        end
      S_EMIT:
      begin
        nxt_st.diag_vld = 1'b1;
        // the index is captured before the counter moves so diag_id names the message in flight
        nxt_st.diag_id  = st_q.emit_idx;
        nxt_st.emit_idx = st_q.emit_idx + 8'h1;
        if (st_q.logcnt[st_q.ch] != 8'hff)
          nxt_st.logcnt[st_q.ch] = st_q.logcnt[st_q.ch] + 8'h1;
        if (st_q.emit_idx == 8'(N_DIAG - 1))
        begin
          nxt_st.state = S_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      S_ENC:
        if (enc_rsp.done)
        begin
          if (st_q.enc.mode == ENC_POS2)
          begin
            nxt_st.ofs[st_q.ch]         = ofs_new;
            nxt_st.resp[st_q.ch][47:16] = ofs_new;
          end
          nxt_st.stat[st_q.ch] = STAT_OK;
          nxt_st.state         = S_IDLE;
          ev[IRQ_DONE]         = 1'b1;
        end
    endcase

    if (rd)
    begin
      case (addr)
        A_INFO:   nxt_st.rdata = st_q.info;
        A_DIAG:   nxt_st.rdata = st_q.diag;
        A_ENG:    nxt_st.rdata = {24'h0, st_q.state, st_q.req_len, st_q.txt_bad, st_q.np_done};
        A_IRQ_ST: nxt_st.rdata = {28'h0, st_q.irq_st};
        A_IRQ_EN: nxt_st.rdata = {28'h0, st_q.irq_en};
        default:
          if (in_ch(addr))
          begin
            case (addr[3:2])
              R_STAT:  nxt_st.rdata = {16'h0, st_q.logcnt[addr[4]], st_q.stat[addr[4]]};
              R_RESP0: nxt_st.rdata = st_q.resp[addr[4]][31:0];
              R_RESP1: nxt_st.rdata = {16'h0, st_q.resp[addr[4]][47:32]};
              default: nxt_st.rdata = st_q.ofs[addr[4]];
            endcase
          end
      endcase
    end

    // a new event outranks a clear landing in the same cycle
    nxt_st.irq_st = (st_q.irq_st & ~clr) | ev;
    nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_en);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q        <= '0;
      st_q.state  <= S_IDLE;
      st_q.irq_en <= IRQ_EN_RST;
    end
    else
      st_q <= nxt_st;
  end

  assign rdata                      = st_q.rdata;
  assign np_fetch                   = st_q.np_fetch;
  assign enc_req                    = st_q.enc;
  assign transmit_data_invalid_flag = st_q.tx_inv;
  assign diag_vld                   = st_q.diag_vld;
  assign diag_id                    = st_q.diag_id;
  assign diag_ch                    = st_q.ch;
  assign irq                        = st_q.irq;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_np_preop;
    $rose(st_q.np_done) |-> $past(st_q.preop_q) && st_q.info == $past(np.info);
  endproperty
  a_np_preop: assert property (p_np_preop) else $error("nameplate taken outside preop");

  property p_chan;
    go |=> st_q.ch == $past(ch_in);
  endproperty
  a_chan: assert property (p_chan) else $error("channel not latched");

  property p_order;
    go |=> st_q.code == $past(code_in) && st_q.resp[st_q.ch][15:0] == st_q.code;
  endproperty
  a_order: assert property (p_order) else $error("command byte order wrong");

  property p_bad_text;
    go && st_q.txt_bad |=> st_q.stat[$past(ch_in)] == STAT_ERR && st_q.state == S_IDLE;
  endproperty
  a_bad_text: assert property (p_bad_text) else $error("unseparated entry accepted");

  property p_log_clr;
    cmd_ok && code_in == CMD_DIAG_CLR |=> st_q.logcnt[$past(ch_in)] == 8'h00;
  endproperty
  a_log_clr: assert property (p_log_clr) else $error("history not cleared");

  property p_emit;
    cmd_ok && code_in == CMD_DIAG_TEST |=> st_q.state == S_EMIT ##1 diag_vld && diag_id == 8'h00;
  endproperty
  a_emit: assert property (p_emit) else $error("diag test did not emit");

  property p_enc_rst;
    cmd_ok && code_in == CMD_ENC_RST |=> enc_req.req && enc_req.mode == ENC_RESET && enc_req.clr_words;
  endproperty
  a_enc_rst: assert property (p_enc_rst) else $error("reset mode command missing");

  property p_ofs;
    st_q.state == S_ENC && enc_rsp.done && st_q.enc.mode == ENC_POS2 |=> st_q.ofs[st_q.ch] == $past(ofs_new);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset not stored");

  property p_supp_out;
    st_q.supp[0] |=> !transmit_data_invalid_flag[0];
  endproperty
  a_supp_out: assert property (p_supp_out) else $error("invalid flag not suppressed");

  property p_done_ok;
    st_q.state == S_ENC && enc_rsp.done |=> st_q.stat[st_q.ch] == STAT_OK && st_q.state == S_IDLE;
  endproperty
  a_done_ok: assert property (p_done_ok) else $error("status not set to one");

  property p_supp_hold;
    st_q.supp[0] && !reference_mark_flag[0] |=> st_q.supp[0];
  endproperty
  a_supp_hold: assert property (p_supp_hold) else $error("suppression dropped early");

  property p_diag_stat;
    cmd_ok && (code_in == CMD_DIAG_CLR || code_in == CMD_DIAG_TEST) |=> st_q.stat[$past(ch_in)] == STAT_IDLE;
  endproperty
  a_diag_stat: assert property (p_diag_stat) else $error("diag command set status");

endmodule // eci_cmd_interp
`default_nettype wire

//--- verification/eci_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the encoder link and the nameplate fetch logic
module eci_enc_model
  import eci_pkg::*;
#(
  parameter logic [31:0] INFO_W = 32'h1234_5678,
  parameter logic [31:0] DIAG_W = 32'h9abc_def0
)(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [3:0]   lat,
  input  wire logic [31:0]  pos1,
  input  wire logic [31:0]  pos2,
  input  wire eci_enc_req_t enc_req,
  output eci_enc_rsp_t      enc_rsp,
  input  wire logic         np_fetch,
  output eci_np_t           np
);
  int cnt;
  int npc;
  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt <= 0;
      npc <= 0;
      enc_rsp <= '0;
      np <= '0;
    end
    else
    begin
      // positions toggle outside done so a stale sample never looks right
      enc_rsp.done <= 1'b0;
      enc_rsp.first_position_value <= ~enc_rsp.first_position_value;
      enc_rsp.second_position_value <= ~enc_rsp.second_position_value;
      if (enc_req.req)
        cnt <= int'(lat) + 1;
      else if (cnt > 1)
        cnt <= cnt - 1;
      else if (cnt == 1)
      begin
        cnt <= 0;
        enc_rsp <= '{1'b1, pos1, pos2};
      end
      np.vld <= 1'b0;
      np.info <= ~np.info;
      np.diag <= ~np.diag;
      if (np_fetch)
        npc <= 3;
      else if (npc > 1)
        npc <= npc - 1;
      else if (npc == 1)
      begin
        npc <= 0;
        np <= '{1'b1, INFO_W, DIAG_W};
      end
    end
  end
endmodule // eci_enc_model
`default_nettype wire

//--- verification/eci_cmd_interp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eci_cmd_interp_tb;
  import eci_pkg::*;
  localparam int ND = 8;
  localparam logic [31:0] INFO_W = 32'h1234_5678;
  localparam logic [31:0] DIAG_W = 32'h9abc_def0;
  logic           clk = 1'b0;
  logic           srst = 1'b1;
  logic [7:0]     addr = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic           preop = 1'b0;
  logic [NCH-1:0] refm = '0;
  logic [NCH-1:0] rawi = '0;
  logic [3:0]     lat = 4'h0;
  logic [31:0]    pos1 = 32'h0000_0100;
  logic [31:0]    pos2 = 32'h0000_0040;
  logic [31:0]    rdata;
  eci_np_t        np;
  logic           np_fetch;
  eci_enc_req_t   enc_req;
  eci_enc_req_t   ecap;
  eci_enc_rsp_t   enc_rsp;
  logic [NCH-1:0] txi;
  logic           diag_vld;
  logic [7:0]     diag_id;
  logic           diag_ch;
  logic           irq;
  logic [7:0]     dlast;
  logic           dchan;
  logic [31:0]    d;
  int             errors = 0;
  int             comparisons = 0;
  int             dcnt = 0;
  int             npf = 0;
  int             erq = 0;
  int             base;

  always #2 clk = ~clk;

  eci_cmd_interp #(.N_DIAG(ND)) uut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .preop(preop), .np(np), .np_fetch(np_fetch), .enc_req(enc_req), .enc_rsp(enc_rsp),
    .reference_mark_flag(refm), .raw_tx_invalid(rawi), .transmit_data_invalid_flag(txi),
    .diag_vld(diag_vld), .diag_id(diag_id), .diag_ch(diag_ch), .irq(irq)
  );
  eci_enc_model #(.INFO_W(INFO_W), .DIAG_W(DIAG_W)) partner (
    .clk(clk), .srst(srst), .lat(lat), .pos1(pos1), .pos2(pos2), .enc_req(enc_req),
    .enc_rsp(enc_rsp), .np_fetch(np_fetch), .np(np)
  );

  always @(posedge clk)
  begin
    if (diag_vld)
    begin
      dcnt++;
      dlast = diag_id;
      dchan = diag_ch;
    end
    if (np_fetch)
      npf++;
    if (enc_req.req)
    begin
      erq++;
      ecap = enc_req;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 300; i++)
    begin
      rreg(A_ENG, d);
      if (d[7:5] === 3'b001)
        return;
    end
    errors++;
    finish_test();
  endtask

  function automatic logic [7:0] chad(input logic ch, input logic [1:0] r);
    return {3'b010, ch, r, 2'b00};
  endfunction

  task automatic cmd(input logic [15:0] code, input logic ch);
    wreg(A_REQ_BYTE, {24'h0, code[7:0]});
    wreg(A_REQ_BYTE, {24'h0, code[15:8]});
    wreg(A_EXEC, {31'h0, ch});
    wait_idle();
  endtask

  task automatic t_reset();
    rreg(A_IRQ_EN, d);
    chk(d, {28'h0, IRQ_EN_RST});
    chk({31'h0, irq}, 32'h0);
    rreg(8'hfc, d);
    chk(d, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_nameplate();
    @(posedge clk);
    preop <= 1'b1;
    repeat (12) @(posedge clk);
    chk(npf, 1);
    rreg(A_INFO, d);
    chk(d, INFO_W);
    rreg(A_DIAG, d);
    chk(d, DIAG_W);
    preop <= 1'b0;
    repeat (12) @(posedge clk);
    chk(npf, 1);
    $display("test nameplate done");
  endtask

  task automatic t_diag();
    base = dcnt;
    cmd(CMD_DIAG_TEST, 1'b1);
    chk(dcnt - base, ND);
    chk({24'h0, dlast}, ND - 1);
    chk({31'h0, dchan}, 32'h1);
    rreg(chad(1'b1, R_STAT), d);
    chk(d[15:0], 16'h0800);
    rreg(chad(1'b1, R_RESP0), d);
    chk(d[15:0], 16'h1001);
    cmd(CMD_DIAG_CLR, 1'b1);
    rreg(chad(1'b1, R_STAT), d);
    chk(d[15:0], 16'h0000);
    $display("test diag done");
  endtask

  task automatic t_enc_reset();
    wreg(A_IRQ_CLR, 32'hf);
    wreg(A_IRQ_EN, 32'h1); // done interrupt only
    lat <= 4'h9;
    base = erq;
    cmd(CMD_ENC_RST, 1'b0);
    chk(erq - base, 1);
    chk({ecap.mode, ecap.clr_words, ecap.ch}, {ENC_RESET, 1'b1, 1'b0});
    rreg(chad(1'b0, R_STAT), d);
    chk(d[7:0], STAT_OK);
    rreg(chad(1'b0, R_RESP0), d);
    chk(d[15:0], CMD_ENC_RST);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wreg(A_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wreg(A_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wreg(A_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test encoder reset done");
  endtask

  task automatic t_offset();
    refm <= 2'b10;
    lat <= 4'h0;
    cmd(CMD_OFS_CALC, 1'b1);
    rreg(chad(1'b1, R_OFS), d);
    chk(d, pos1 - pos2);
    rreg(chad(1'b1, R_STAT), d);
    chk(d[7:0], STAT_OK);
    $display("test offset done");
  endtask

  task automatic t_suppress();
    rawi <= 2'b01;
    cmd(CMD_SUPP, 1'b0);
    repeat (20) @(posedge clk);
    chk({31'h0, txi[0]}, 32'h0);
    refm <= 2'b11;
    repeat (4) @(posedge clk);
    chk({31'h0, txi[0]}, 32'h1);
    $display("test suppress done");
  endtask

  task automatic txt(input string s, input logic [7:0] exp);
    for (int i = 0; i < s.len(); i++)
      wreg(A_REQ_TEXT, {24'h0, s[i]});
    wreg(A_EXEC, 32'h0);
    wait_idle();
    rreg(chad(1'b0, R_STAT), d);
    chk(d[7:0], exp);
  endtask

  task automatic t_header();
    wreg(A_REQ_BYTE, 32'h0000_0000);
    wreg(A_REQ_BYTE, 32'h0000_0010);
    wreg(A_REQ_BYTE, 32'h0000_00a7);
    wreg(A_REQ_BYTE, 32'h0000_0004);
    wreg(A_REQ_BYTE, 32'h0000_0001);
    wreg(A_EXEC, 32'h0);
    wait_idle();
    rreg(chad(1'b0, R_STAT), d);
    chk(d[7:0], STAT_IDLE);
    rreg(chad(1'b0, R_RESP0), d);
    chk(d, 32'h0000_1000);
    $display("test header done");
  endtask

  task automatic t_text();
    txt("0180", STAT_ERR);
    txt("01 80", STAT_OK);
    $display("test text entry done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_nameplate();
    t_diag();
    t_enc_reset();
    t_offset();
    t_suppress();
    t_text();
    t_header();
    finish_test();
  end
endmodule // eci_cmd_interp_tb
`default_nettype wire
